// *** include/adc_readout_map.vh ***
`ifndef ADC_READOUT_MAP_VH
`define ADC_READOUT_MAP_VH
`define RESULT_WIDTH 18
`define RESULT_TOP 17
`define CHAIN_DELAY 18
`define CFG_WIDTH 16
`define CFG_CNT_W 5
`define BIT_CNT_W 5
`define FIFO_WIDTH 18
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define CONV_TIME_NS 320
`define CLK_PERIOD_NS 25
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CNT_W 5
`define CONV_CNT_INIT 5'h00
// conversion cycles minus one, loaded at the convert rise
`define CONV_CNT_LOAD 5'h0C
// count of the last configuration bit
`define CFG_LAST 5'h0F
// falls after which the chain delay line feeds the output
`define CHAIN_TAP 5'h11
`define STYLE_CHAIN 1'b0
`define STYLE_SELECT 1'b1
`endif

// *** hw/sample_fifo_mem.v ***
`timescale 1ns/1ps
module sample_fifo_mem #(
  parameter WIDTH = 18,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock
  input wire core_clk,
  // write side
  input wire wrEn,
  input wire [AW-1:0] wrAddr,
  input wire [WIDTH-1:0] wrData,
  // read side
  input wire [AW-1:0] rdAddr,
  output reg [WIDTH-1:0] rdData_r
);
  reg [WIDTH-1:0] store [0:DEPTH-1];

  always @(posedge core_clk)
  begin
    if (wrEn)
    begin
      store[wrAddr] <= wrData;
    end
    rdData_r <= store[rdAddr];
  end
endmodule // sample_fifo_mem

// *** hw/sample_fifo.v ***
`timescale 1ns/1ps
module sample_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // drain side
  output reg outValid_r,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [AW:0] wrPtr_r;
  reg [AW:0] rdPtr_r;
  wire [AW:0] used;
  wire memEmpty;
  wire pull;
  wire push;
  wire [AW-1:0] rdSel;

  assign used = wrPtr_r - rdPtr_r;
  // the word in the output register keeps its slot until replaced, so
  // the memory takes one word fewer; rereading that slot holds outData
  assign inReady = (used != {1'b0, {AW{1'b1}}});
  assign rdSel = pull ? rdPtr_r[AW-1:0] : rdPtr_r[AW-1:0] - 1'b1;
  assign memEmpty = (used == {(AW+1){1'b0}});
  assign push = inValid & inReady;
  assign pull = !memEmpty & (!outValid_r | outReady);

  sample_fifo_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) mem (
    .core_clk(core_clk),
    .wrEn(push),
    .wrAddr(wrPtr_r[AW-1:0]),
    .wrData(inData),
    .rdAddr(rdSel),
    .rdData_r(outData)
  );

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      wrPtr_r <= {(AW+1){1'b0}};
      rdPtr_r <= {(AW+1){1'b0}};
      outValid_r <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pull)
      begin
        rdPtr_r <= rdPtr_r + 1'b1;
        outValid_r <= 1'b1;
      end
      else if (outReady)
      begin
        outValid_r <= 1'b0;
      end
    end
  end
endmodule // sample_fifo

// *** hw/adc_serial_readout.v ***
// Notes on behaviour
// - convert rise starts conversion, picks style
// - serial_in low at rise: daisy-chain style
// - serial_in high at rise: select style
// - select style: output on while convert/serial_in low
// - daisy-chain readout happens while convert high
// - chain input reappears eighteen shift clocks later
// - one result bit per shift clock
// - select style: busy indicator armed if low at finish
// - convert low: capture sixteen-bit configuration word
// - result top bit presented first
// - output changes on shift clock falling edge
// - chain input sampled on shift clock rise
// - convert rise returns output to high impedance
`timescale 1ns/1ps
`include "adc_readout_map.vh"
module adc_serial_readout (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // pins from the host
  input wire convertStart,
  input wire shiftClk,
  input wire serialIn,
  // serial output pin
  output reg serialOut_r,
  output reg serialOutEn_r,
  // conversion results from the converter core
  input wire sampleValid,
  output wire sampleReady,
  input wire [`RESULT_WIDTH-1:0] sampleData,
  // status towards the core
  output reg converting_r,
  output reg chainStyle_r,
  output reg busyArmed_r,
  output reg [`CFG_WIDTH-1:0] configWord_r,
  output reg configStrobe_r
);
  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_READ = 3'b100;

  // two-flop synchronisers; first stage read only by second
  reg [2:0] syncA_r;
  reg [2:0] syncB_r;
  reg [2:0] prev_r;
  wire convert_start;
  wire sck;
  wire serial_in;
  wire cnvRise;
  wire sckRise;
  wire sckFall;

  reg [2:0] state_r;
  reg [`CONV_CNT_W-1:0] convCnt_r;
  reg [`RESULT_WIDTH-1:0] shiftReg_r;
  reg [`CHAIN_DELAY-1:0] chainReg_r;
  reg [`BIT_CNT_W-1:0] bitCnt_r;
  reg [`CFG_WIDTH-1:0] cfgShift_r;
  reg [`CFG_CNT_W-1:0] cfgCnt_r;
  reg loaded_r;
  reg [`RESULT_WIDTH-1:0] result_r;
  wire fifoValid;
  wire [`RESULT_WIDTH-1:0] fifoData;
  wire fifoInReady;
  wire fifoInValid;
  reg sampleReady_r;
  wire takeSample;
  wire enable;

  assign convert_start = syncB_r[0];
  assign sck = syncB_r[1];
  assign serial_in = syncB_r[2];
  assign cnvRise = convert_start & !prev_r[0];
  assign sckRise = sck & !prev_r[1];
  assign sckFall = !sck & prev_r[1];

  // samples queue up so the core stalls on a slow host only once sixteen are waiting
  sample_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(sampleData),
    .outValid_r(fifoValid),
    .outReady(takeSample),
    .outData(fifoData)
  );

  // ready from a flop; one idle cycle after each word keeps full exact
  assign sampleReady = sampleReady_r;
  assign fifoInValid = sampleValid & sampleReady_r;

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sampleReady_r <= 1'b0;
    end
    else if (fifoInValid)
    begin
      sampleReady_r <= 1'b0;
    end
    else
    begin
      sampleReady_r <= fifoInReady;
    end
  end

  // a result is consumed when a conversion finishes
  assign takeSample = (state_r == ST_CONV) &&
    (convCnt_r == `CONV_CNT_INIT) && fifoValid;

  // select-style enable from either pin being low
  assign enable = !convert_start | !serial_in;

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      syncA_r <= 3'b000;
      syncB_r <= 3'b000;
      prev_r <= 3'b000;
    end
    else
    begin
      syncA_r <= {serialIn, shiftClk, convertStart};
      syncB_r <= syncA_r;
      prev_r <= syncB_r;
    end
  end

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_r <= ST_IDLE;
      convCnt_r <= `CONV_CNT_INIT;
      converting_r <= 1'b0;
      chainStyle_r <= `STYLE_CHAIN;
      busyArmed_r <= 1'b0;
      loaded_r <= 1'b0;
      result_r <= {`RESULT_WIDTH{1'b0}};
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (cnvRise)
          begin
            state_r <= ST_CONV;
            converting_r <= 1'b1;
            convCnt_r <= `CONV_CNT_LOAD;
            // style latched here, held to next rise
            chainStyle_r <= serial_in ? `STYLE_SELECT : `STYLE_CHAIN;
            busyArmed_r <= 1'b0;
          end
        end
        ST_CONV:
        begin
          if (convCnt_r != `CONV_CNT_INIT)
          begin
            convCnt_r <= convCnt_r - 1'b1;
          end
          else
          begin
            // empty queue gives last result rather than stalling
            if (fifoValid)
            begin
              result_r <= fifoData;
            end
            state_r <= ST_READ;
            converting_r <= 1'b0;
            loaded_r <= 1'b1;
            busyArmed_r <= (chainStyle_r == `STYLE_SELECT) &&
              enable;
          end
        end
        ST_READ:
        begin
          loaded_r <= 1'b0;
          if (cnvRise)
          begin
            state_r <= ST_CONV;
            converting_r <= 1'b1;
            convCnt_r <= `CONV_CNT_LOAD;
            chainStyle_r <= serial_in ? `STYLE_SELECT : `STYLE_CHAIN;
            busyArmed_r <= 1'b0;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // shift path; host respects conversion time before clocking
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      shiftReg_r <= {`RESULT_WIDTH{1'b0}};
      chainReg_r <= {`CHAIN_DELAY{1'b0}};
      bitCnt_r <= {`BIT_CNT_W{1'b0}};
      serialOut_r <= 1'b0;
      serialOutEn_r <= 1'b0;
    end
    else
    begin
      if (loaded_r)
      begin
        shiftReg_r <= result_r;
        chainReg_r <= {`CHAIN_DELAY{1'b0}};
        bitCnt_r <= {`BIT_CNT_W{1'b0}};
        serialOut_r <= result_r[`RESULT_TOP];
      end
      else if (state_r == ST_READ)
      begin
        if (chainStyle_r == `STYLE_CHAIN)
        begin
          if (convert_start && sckRise)
          begin
            chainReg_r <= {chainReg_r[`CHAIN_DELAY-2:0], serial_in};
          end
          if (convert_start && sckFall)
          begin
            // result bits first, then the far end of the delay line;
            // tapping it directly keeps the pass-through at 18 clocks
            if (bitCnt_r == `CHAIN_TAP)
            begin
              serialOut_r <= chainReg_r[`CHAIN_DELAY-1];
            end
            else
            begin
              shiftReg_r <= {shiftReg_r[`RESULT_WIDTH-2:0], 1'b0};
              serialOut_r <= shiftReg_r[`RESULT_WIDTH-2];
              bitCnt_r <= bitCnt_r + 1'b1;
            end
          end
          serialOutEn_r <= convert_start;
        end
        else
        begin
          if (enable && sckFall)
          begin
            shiftReg_r <= {shiftReg_r[`RESULT_WIDTH-2:0], 1'b0};
            serialOut_r <= shiftReg_r[`RESULT_WIDTH-2];
            bitCnt_r <= bitCnt_r + 1'b1;
          end
          serialOutEn_r <= enable;
        end
      end
      if (cnvRise)
      begin
        serialOutEn_r <= 1'b0;
      end
    end
  end

  // configuration word, independent of readout
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cfgShift_r <= {`CFG_WIDTH{1'b0}};
      cfgCnt_r <= {`CFG_CNT_W{1'b0}};
      configWord_r <= {`CFG_WIDTH{1'b0}};
      configStrobe_r <= 1'b0;
    end
    else
    begin
      configStrobe_r <= 1'b0;
      if (convert_start)
      begin
        cfgCnt_r <= {`CFG_CNT_W{1'b0}};
      end
      else if (sckRise)
      begin
        cfgShift_r <= {cfgShift_r[`CFG_WIDTH-2:0], serial_in};
        if (cfgCnt_r == `CFG_LAST)
        begin
          configWord_r <= {cfgShift_r[`CFG_WIDTH-2:0], serial_in};
          configStrobe_r <= 1'b1;
          cfgCnt_r <= {`CFG_CNT_W{1'b0}};
        end
        else
        begin
          cfgCnt_r <= cfgCnt_r + 1'b1;
        end
      end
    end
  end
endmodule // adc_serial_readout

// *** verification/adc_serial_readout_asserts.sv ***
`timescale 1ns/1ps
module adc_serial_readout_asserts (
  // clock and reset
  input logic core_clk,
  input logic sys_rst,
  // pins and status
  input logic convertStart,
  input logic shiftClk,
  input logic serialIn,
  input logic serialOut_r,
  input logic serialOutEn_r,
  input logic converting_r,
  input logic chainStyle_r,
  input logic busyArmed_r,
  input logic configStrobe_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence convRun;
    ##12 converting_r ##1 !converting_r;
  endsequence
  a_conv_start: assert property ($rose(convertStart) |->
    ##[2:4] $rose(converting_r)) else $error("no start");
  a_conv_len: assert property ($rose(converting_r) |-> convRun)
    else $error("bad length");
  a_style_pick: assert property ($rose(converting_r) |->
    chainStyle_r == $past(serialIn, 3)) else $error("bad style");
  a_style_held: assert property (!$rose(converting_r) |->
    $stable(chainStyle_r)) else $error("style moved");
  a_out_hiz: assert property ($rose(convertStart) |->
    ##[1:4] !serialOutEn_r) else $error("no release");
  a_sel_enable: assert property ($rose(serialOutEn_r) && chainStyle_r
    |-> !$past(convertStart, 3) || !$past(serialIn, 3))
    else $error("bad enable");
  a_chain_enable: assert property ($rose(serialOutEn_r)
    && !chainStyle_r |-> $past(convertStart, 3))
    else $error("bad enable");
  a_out_fall: assert property ($changed(serialOut_r) |->
    !$past(shiftClk, 3)) else $error("shift off fall");
  a_busy_sel: assert property ($rose(busyArmed_r) |->
    chainStyle_r && !converting_r) else $error("bad busy");
  a_cfg_pulse: assert property (configStrobe_r |->
    !$past(convertStart, 3) ##1 !configStrobe_r)
    else $error("bad strobe");
endmodule // adc_serial_readout_asserts

bind adc_serial_readout adc_serial_readout_asserts u_chk (.core_clk,
  .sys_rst, .convertStart, .shiftClk, .serialIn, .serialOut_r,
  .serialOutEn_r, .converting_r, .chainStyle_r, .busyArmed_r,
  .configStrobe_r);

// *** verification/host_model.sv ***
`timescale 1ns/1ps
module host_model (
  // clock
  input logic core_clk,
  // pins
  output logic convertStart = 1'b0,
  output logic shiftClk = 1'b0,
  output logic serialIn = 1'b1,
  input logic serialOut_r
);
  // sdi held across the convert edge picks the style
  task automatic pins(input logic c, input logic s, input int n);
    convertStart <= c;
    serialIn <= s;
    repeat (n) @(negedge core_clk);
  endtask
  // sck idles low; one bit per 200 ns, read just before the rise
  task automatic shift(input int n, input logic [35:0] din,
    output logic [35:0] dout);
    dout = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serialIn <= din[i];
      repeat (4) @(negedge core_clk);
      dout[i] = serialOut_r;
      shiftClk <= 1'b1;
      repeat (4) @(negedge core_clk);
      shiftClk <= 1'b0;
    end
  endtask
endmodule // host_model

// *** verification/adc_serial_readout_tb.sv ***
`timescale 1ns/1ps
module adc_serial_readout_tb;
  logic core_clk;
  logic sys_rst = 1'b1;
  logic convertStart, shiftClk, serialIn, serialOut_r, serialOutEn_r;
  logic sampleValid = 1'b0;
  logic sampleReady;
  logic [17:0] sampleData = 18'h0_0000;
  logic converting_r, chainStyle_r, busyArmed_r, configStrobe_r;
  logic [15:0] configWord_r;
  logic [35:0] d;
  int fail_count = 0;
  int checks = 0;
  int n;
  adc_serial_readout u_adc_serial_readout (.core_clk, .sys_rst,
    .convertStart, .shiftClk, .serialIn, .serialOut_r, .serialOutEn_r,
    .sampleValid, .sampleReady, .sampleData, .converting_r,
    .chainStyle_r, .busyArmed_r, .configWord_r, .configStrobe_r);
  host_model u_host_model (.core_clk, .convertStart, .shiftClk,
    .serialIn, .serialOut_r);
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  function automatic logic [17:0] val(input int i);
    return 18'h2_5A3C ^ {i[3:0], 14'h0000};
  endfunction
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic push(input logic [17:0] v);
    sampleData <= v;
    sampleValid <= 1'b1;
    @(negedge core_clk);
    sampleValid <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic cfg_write();
    u_host_model.shift(16, 36'h0_0000_A5C3, d);
    repeat (4) @(negedge core_clk);
    chk(36'(configWord_r), 36'h0_0000_A5C3);
    $display("done: config");
  endtask
  task automatic fill();
    n = 0;
    while (sampleReady === 1'b1 && n < 20)
    begin
      push(val(n));
      n++;
    end
    chk(36'(n), 36'h0_0000_0010);
    $display("done: fill");
  endtask
  // sdi low during conversion arms the busy flag
  task automatic sel_read(input logic [17:0] v, input logic bsy);
    u_host_model.pins(1'b1, 1'b1, 6);
    chk(36'(serialOutEn_r), 36'h0);
    chk(36'(chainStyle_r), 36'h1);
    chk(36'(converting_r), 36'h1);
    u_host_model.pins(1'b1, !bsy, 18);
    chk(36'(converting_r), 36'h0);
    chk(36'(busyArmed_r), 36'(bsy));
    u_host_model.pins(1'b0, 1'b1, 4);
    chk(36'(serialOutEn_r), 36'h1);
    u_host_model.shift(18, '1, d);
    chk(d, 36'(v));
    $display("done: select read");
  endtask
  task automatic chain_read(input logic [17:0] v, input logic [17:0] p);
    u_host_model.pins(1'b0, 1'b0, 4);
    u_host_model.pins(1'b1, 1'b0, 6);
    chk(36'(chainStyle_r), 36'h0);
    u_host_model.pins(1'b1, 1'b0, 18);
    chk(36'(serialOutEn_r), 36'h1);
    u_host_model.shift(36, {p, 18'h0_0000}, d);
    chk(d, {v, p});
    $display("done: chain read");
  endtask
  initial
  begin
    repeat (5) @(negedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(negedge core_clk);
    cfg_write();
    fill();
    for (int i = 0; i < 16; i++)
      sel_read(val(i), i == 15);
    // empty buffer: last result comes again
    sel_read(val(15), 1'b0);
    push(18'h1_2345);
    chain_read(18'h1_2345, 18'h2_A5A5);
    close_out();
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    close_out();
  end
endmodule // adc_serial_readout_tb
